// file: core/tcr_cfg.svh
`ifndef TCR_CFG_SVH
`define TCR_CFG_SVH
// Register byte offsets
`define TCR_OFF_AUX_CTRL   8'h14
`define TCR_OFF_CORE_CTRL  8'h18
`define TCR_OFF_AUX_CNT    8'h2C
`define TCR_OFF_CORE_CNT   8'h30
`define TCR_OFF_CAP_VAL    8'h34
`define TCR_OFF_PORT_SEL   8'h38
// Reset values
`define TCR_RST_CTRL       16'h0000
`define TCR_RST_CNT        16'h0000
// Writable bits of the control registers
`define TCR_MASK_CORE      16'hDEFF
`define TCR_MASK_AUX       16'hF6FF
// Count limits
`define TCR_CNT_MAX        16'hFFFF
`define TCR_CNT_ZERO       16'h0000
// Block prescaler terminal counts, factor minus one
`define TCR_PS_DIV2        4'h1
`define TCR_PS_DIV4        4'h3
`define TCR_PS_DIV8        4'h7
`define TCR_PS_DIV16       4'hF
// Block prescaler encodings
`define TCR_BPS_DIV2       2'b01
`define TCR_BPS_DIV4       2'b00
`define TCR_BPS_DIV8       2'b11
// Timer modes
`define TCR_MODE_TIMER     3'b000
`define TCR_MODE_COUNTER   3'b001
// Bus responses
`define TCR_RESP_OKAY      2'b00
`define TCR_RESP_SLVERR    2'b10
`endif

// file: core/tcr_pkg.sv
package tcr_pkg;
  typedef struct packed {
    logic       reload_en;
    logic       clr;
    logic       rsv13;
    logic [1:0] bps;
    logic       latch;
    logic       oe;
    logic       ude;
    logic       down;
    logic       run;
    logic [2:0] mode;
    logic [2:0] tin;
  } tcr_core_ctrl_t;

  typedef struct packed {
    logic       capture_en;
    logic       clr;
    logic [1:0] edge_sel;
    logic       rsv11;
    logic       enc_sel;
    logic       remote;
    logic       ude;
    logic       down;
    logic       run;
    logic [2:0] mode;
    logic [2:0] tin;
  } tcr_aux_ctrl_t;

  typedef enum logic [2:0] {
    TCR_SEL_NONE = 3'd0,
    TCR_SEL_ACTL = 3'd1,
    TCR_SEL_CCTL = 3'd2,
    TCR_SEL_AUX  = 3'd3,
    TCR_SEL_CORE = 3'd4,
    TCR_SEL_CAP  = 3'd5,
    TCR_SEL_PSEL = 3'd6
  } tcr_sel_t;
endpackage : tcr_pkg

// file: core/tcr_timer_capture_reload.sv
`timescale 1ns/1ps
`include "tcr_cfg.svh"
module tcr_timer_capture_reload #(
  parameter int AW = 8
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          ce,
  input  wire logic [AW-1:0] s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [AW-1:0] s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  input  wire logic          capture_input_pin,
  input  wire logic          encoder_count_input,
  input  wire logic          encoder_direction_input,
  input  wire logic          aux_count_pin,
  input  wire logic          core_count_pin,
  input  wire logic          enc_read_a,
  input  wire logic          enc_read_b,
  input  wire logic          enc_read_c,
  output logic               capture_irq_line,
  output logic               core_timer_irq_line,
  output logic               core_underflow_pulse,
  output logic               toggle_output_pin
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions
  function automatic logic hit2(input logic [1:0] sel, input logic a, input logic b);
    hit2 = (sel[0] & a) | (sel[1] & b);
  endfunction : hit2

  function automatic logic [6:0] pmask(input logic [2:0] s);
    pmask = 7'h7F >> (3'd7 - s);
  endfunction : pmask

  function automatic logic [3:0] ps_lim(input logic [1:0] b);
    case (b)
      `TCR_BPS_DIV2: ps_lim = `TCR_PS_DIV2;
      `TCR_BPS_DIV4: ps_lim = `TCR_PS_DIV4;
      `TCR_BPS_DIV8: ps_lim = `TCR_PS_DIV8;
      default:       ps_lim = `TCR_PS_DIV16;
    endcase
  endfunction : ps_lim

  function automatic tcr_pkg::tcr_sel_t dec(input logic [AW-1:0] a);
    case (a[7:0])
      `TCR_OFF_AUX_CTRL:  dec = tcr_pkg::TCR_SEL_ACTL;
      `TCR_OFF_CORE_CTRL: dec = tcr_pkg::TCR_SEL_CCTL;
      `TCR_OFF_AUX_CNT:   dec = tcr_pkg::TCR_SEL_AUX;
      `TCR_OFF_CORE_CNT:  dec = tcr_pkg::TCR_SEL_CORE;
      `TCR_OFF_CAP_VAL:   dec = tcr_pkg::TCR_SEL_CAP;
      `TCR_OFF_PORT_SEL:  dec = tcr_pkg::TCR_SEL_PSEL;
      default:            dec = tcr_pkg::TCR_SEL_NONE;
    endcase
    if ((a >> 8) != '0) begin
      dec = tcr_pkg::TCR_SEL_NONE;
    end
  endfunction : dec

  function automatic logic [15:0] wmerge(input logic [15:0] o, input logic [31:0] d,
                                         input logic [3:0] s);
    wmerge = {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
  endfunction : wmerge

  ////////////////////////////////////////////////////////////////////////////
  // State
  tcr_pkg::tcr_core_ctrl_t cctl_ff;
  tcr_pkg::tcr_aux_ctrl_t  actl_ff;
  logic [15:0]             aux_cnt_ff;
  logic [15:0]             core_cnt_ff;
  logic [15:0]             cap_ff;
  logic                    psel_ff;
  logic [3:0]              ps_ff;
  logic [6:0]              pre_ff;
  logic [4:0]              sy1_ff;
  logic [4:0]              sy2_ff;
  logic [4:0]              smp_ff;
  logic                    rd_pend_ff;
  logic                    aw_v_ff;
  logic                    w_v_ff;
  logic [AW-1:0]           awaddr_ff;
  logic [31:0]             wdata_ff;
  logic [3:0]              wstrb_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Basic clock prescaler
  logic basic_tick;
  assign basic_tick = (ps_ff >= ps_lim(cctl_ff.bps));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ps_ff  <= 4'h0;
      pre_ff <= 7'h00;
    end else if (ce) begin
      ps_ff <= basic_tick ? 4'h0 : ps_ff + 4'h1;
      if (basic_tick) begin
        pre_ff <= pre_ff + 7'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers and basic clock sampling
  logic [4:0] pins;
  logic [4:0] rise;
  logic [4:0] fall;
  assign pins = {core_count_pin, aux_count_pin, encoder_direction_input,
                 encoder_count_input, capture_input_pin};
  assign rise = {5{basic_tick}} & sy2_ff & ~smp_ff;
  assign fall = {5{basic_tick}} & ~sy2_ff & smp_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sy1_ff <= 5'h00;
      sy2_ff <= 5'h00;
      smp_ff <= 5'h00;
    end else if (ce) begin
      sy1_ff <= pins;
      sy2_ff <= sy1_ff;
      if (basic_tick) begin
        smp_ff <= sy2_ff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture trigger
  logic rd_req;
  logic rd_hit;
  logic cap_trig;
  assign rd_req = psel_ff ? (enc_read_a | enc_read_b | enc_read_c) : enc_read_b;
  assign rd_hit = basic_tick & rd_pend_ff;
  always_comb begin
    cap_trig = 1'b0;
    if (basic_tick && actl_ff.edge_sel != 2'b00) begin
      if (actl_ff.enc_sel) begin
        cap_trig = hit2(actl_ff.edge_sel, rise[1] | fall[1], rise[2] | fall[2]);
      end else begin
        cap_trig = hit2(actl_ff.edge_sel, rise[0], fall[0]) |
                   ((actl_ff.edge_sel == 2'b01) & rd_hit);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_pend_ff <= 1'b0;
    end else if (ce) begin
      rd_pend_ff <= rd_req | (rd_pend_ff & ~basic_tick);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Count enables
  logic aux_run;
  logic aux_cnt;
  logic core_cnt;
  logic core_ovf;
  logic core_unf;
  logic core_wrap;
  assign aux_run = actl_ff.remote ? cctl_ff.run : actl_ff.run;
  assign core_ovf = core_cnt & ~cctl_ff.down & (core_cnt_ff == `TCR_CNT_MAX);
  assign core_unf = core_cnt & cctl_ff.down & (core_cnt_ff == `TCR_CNT_ZERO);
  assign core_wrap = core_ovf | core_unf;

  always_comb begin
    core_cnt = 1'b0;
    if (cctl_ff.run && basic_tick) begin
      if (cctl_ff.mode == `TCR_MODE_TIMER) begin
        core_cnt = ((pre_ff & pmask(cctl_ff.tin)) == pmask(cctl_ff.tin));
      end else if (cctl_ff.mode == `TCR_MODE_COUNTER) begin
        core_cnt = hit2(cctl_ff.tin[1:0], rise[4], fall[4]);
      end else if (cctl_ff.mode[2:1] == 2'b01) begin
        core_cnt = ((pre_ff & pmask(cctl_ff.tin)) == pmask(cctl_ff.tin)) &
                   (smp_ff[4] == cctl_ff.mode[0]);
      end
    end
  end

  always_comb begin
    aux_cnt = 1'b0;
    if (aux_run && basic_tick) begin
      if (actl_ff.mode == `TCR_MODE_TIMER) begin
        aux_cnt = ((pre_ff & pmask(actl_ff.tin)) == pmask(actl_ff.tin));
      end else if (actl_ff.mode == `TCR_MODE_COUNTER) begin
        aux_cnt = actl_ff.tin[2] ?
                  hit2(actl_ff.tin[1:0], core_wrap & ~cctl_ff.latch, core_wrap & cctl_ff.latch) :
                  hit2(actl_ff.tin[1:0], rise[3], fall[3]);
      end else if (actl_ff.mode[2:1] == 2'b01) begin
        aux_cnt = ((pre_ff & pmask(actl_ff.tin)) == pmask(actl_ff.tin)) &
                  (smp_ff[3] == actl_ff.mode[0]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  logic                wr_go;
  tcr_pkg::tcr_sel_t   wsel;
  logic [15:0]         wv_cctl;
  assign wr_go = aw_v_ff & w_v_ff & ~s_axi_bvalid;
  assign wsel = dec(awaddr_ff);
  assign wv_cctl = wmerge(cctl_ff, wdata_ff, wstrb_ff) & `TCR_MASK_CORE;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cctl_ff <= `TCR_RST_CTRL;
      actl_ff <= `TCR_RST_CTRL;
      psel_ff <= 1'b0;
    end else if (ce) begin
      if (wr_go && wsel == tcr_pkg::TCR_SEL_CCTL) begin
        cctl_ff <= wv_cctl;
      end
      if (core_wrap) begin
        cctl_ff.latch <= ~cctl_ff.latch;
      end
      if (wr_go && wsel == tcr_pkg::TCR_SEL_ACTL) begin
        actl_ff <= wmerge(actl_ff, wdata_ff, wstrb_ff) & `TCR_MASK_AUX;
      end
      if (wr_go && wsel == tcr_pkg::TCR_SEL_PSEL && wstrb_ff[0]) begin
        psel_ff <= wdata_ff[0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timers and capture register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aux_cnt_ff <= `TCR_RST_CNT;
    end else if (ce) begin
      if (cap_trig && actl_ff.clr) begin
        aux_cnt_ff <= `TCR_CNT_ZERO;
      end else if (wr_go && wsel == tcr_pkg::TCR_SEL_AUX) begin
        aux_cnt_ff <= wmerge(aux_cnt_ff, wdata_ff, wstrb_ff);
      end else if (aux_cnt) begin
        aux_cnt_ff <= actl_ff.down ? aux_cnt_ff - 16'h0001 : aux_cnt_ff + 16'h0001;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_cnt_ff <= `TCR_RST_CNT;
    end else if (ce) begin
      if (cap_trig && cctl_ff.clr) begin
        core_cnt_ff <= `TCR_CNT_ZERO;
      end else if (wr_go && wsel == tcr_pkg::TCR_SEL_CORE) begin
        core_cnt_ff <= wmerge(core_cnt_ff, wdata_ff, wstrb_ff);
      end else if (core_wrap && cctl_ff.reload_en) begin
        core_cnt_ff <= cap_ff;
      end else if (core_cnt) begin
        core_cnt_ff <= cctl_ff.down ? core_cnt_ff - 16'h0001 : core_cnt_ff + 16'h0001;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cap_ff <= `TCR_RST_CNT;
    end else if (ce) begin
      if (cap_trig && actl_ff.capture_en) begin
        cap_ff <= aux_cnt_ff;
      end else if (wr_go && wsel == tcr_pkg::TCR_SEL_CAP) begin
        cap_ff <= wmerge(cap_ff, wdata_ff, wstrb_ff);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      capture_irq_line     <= 1'b0;
      core_timer_irq_line  <= 1'b0;
      core_underflow_pulse <= 1'b0;
      toggle_output_pin    <= 1'b0;
    end else if (ce) begin
      capture_irq_line     <= cap_trig;
      core_timer_irq_line  <= core_wrap;
      core_underflow_pulse <= core_unf;
      toggle_output_pin    <= cctl_ff.oe & cctl_ff.latch;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_v_ff       <= 1'b0;
      w_v_ff        <= 1'b0;
      awaddr_ff     <= '0;
      wdata_ff      <= 32'h0000_0000;
      wstrb_ff      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `TCR_RESP_OKAY;
    end else if (ce) begin
      s_axi_awready <= ~aw_v_ff & ~s_axi_bvalid & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready  <= ~w_v_ff & ~s_axi_bvalid & ~(s_axi_wvalid & s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_v_ff   <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_v_ff   <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_v_ff      <= 1'b0;
        w_v_ff       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wsel == tcr_pkg::TCR_SEL_NONE) ? `TCR_RESP_SLVERR : `TCR_RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  logic [15:0] rmux;
  always_comb begin
    case (dec(s_axi_araddr))
      tcr_pkg::TCR_SEL_ACTL: rmux = actl_ff;
      tcr_pkg::TCR_SEL_CCTL: rmux = cctl_ff;
      tcr_pkg::TCR_SEL_AUX:  rmux = aux_cnt_ff;
      tcr_pkg::TCR_SEL_CORE: rmux = core_cnt_ff;
      tcr_pkg::TCR_SEL_CAP:  rmux = cap_ff;
      tcr_pkg::TCR_SEL_PSEL: rmux = {15'h0000, psel_ff};
      default:               rmux = 16'h0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `TCR_RESP_OKAY;
    end else if (ce) begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {16'h0000, rmux};
        s_axi_rresp  <= (dec(s_axi_araddr) == tcr_pkg::TCR_SEL_NONE) ?
                        `TCR_RESP_SLVERR : `TCR_RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_RELOAD: assert property (ce && core_wrap && cctl_ff.reload_en && !cap_trig && !wr_go
    |=> core_cnt_ff == $past(cap_ff)) else $error("reload value wrong");
  AST_NO_CAP_IRQ: assert property (ce && core_wrap && !cap_trig
    |=> !capture_irq_line && core_timer_irq_line) else $error("reload raised capture line");
  AST_BOTH: assert property (ce && cap_trig && actl_ff.capture_en && cctl_ff.reload_en
    |=> cap_ff == $past(aux_cnt_ff)) else $error("capture lost with reload on");
  AST_TOGGLE: assert property (ce && core_unf
    |=> cctl_ff.latch != $past(cctl_ff.latch)) else $error("latch did not toggle");
  AST_UF_PULSE: assert property (ce && core_unf |=> core_underflow_pulse)
    else $error("underflow pulse missing");
  AST_UF_ONLY: assert property (ce && !(cctl_ff.down && core_cnt && core_cnt_ff == 16'h0000)
    |=> !core_underflow_pulse) else $error("spurious underflow");
  AST_AUX_CLR: assert property (ce && cap_trig && actl_ff.clr
    |=> aux_cnt_ff == 16'h0000) else $error("aux timer not cleared");
  AST_NO_CAP: assert property (actl_ff.edge_sel == 2'b00 |-> !cap_trig)
    else $error("capture with edge select zero");
  AST_TICK_GAP: assert property (ce && basic_tick |=> !basic_tick)
    else $error("basic tick too close");
  AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");

  COV_RELOAD: cover property (ce && core_ovf && cctl_ff.reload_en);
  COV_CAPTURE: cover property (ce && cap_trig && actl_ff.capture_en);
  COV_BOTH: cover property (ce && cap_trig && core_wrap);
  COV_ENC: cover property (ce && cap_trig && actl_ff.enc_sel);

endmodule : tcr_timer_capture_reload

// file: tb/tb.sv
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    logic [33:0] v;
    logic        dc;
  } tcr_rnote_t;
  typedef struct packed {
    int unsigned per;
    logic        uf;
  } tcr_pnote_t;

  logic        aclk, aresetn, req, awv, wv, bre, arv, rre, skip, have_tog, prev_tog;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rdata;
  logic [2:0]  which, rdp;
  logic [4:0]  pins;
  logic [1:0]  bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid, cap_irq, core_irq, uf, tog;
  int          failures, check_count, cyc, last, tog_due, capcnt;
  tcr_rnote_t  rq[$];
  tcr_pnote_t  pq[$];
  tcr_rnote_t  rn;
  tcr_pnote_t  pn;

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  tcr_timer_capture_reload i_tcr_timer_capture_reload (
    .aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awready),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bre),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rre),
    .capture_input_pin(pins[0]), .encoder_count_input(pins[1]),
    .encoder_direction_input(pins[2]), .aux_count_pin(pins[3]), .core_count_pin(pins[4]),
    .enc_read_a(rdp[0]), .enc_read_b(rdp[1]), .enc_read_c(rdp[2]),
    .capture_irq_line(cap_irq), .core_timer_irq_line(core_irq),
    .core_underflow_pulse(uf), .toggle_output_pin(tog));

  tcr_pin_src i_tcr_pin_src (.aclk(aclk), .aresetn(aresetn), .req(req), .which(which),
                             .pins(pins));

  ////////////////////////////////////////
  // Compare and report
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wrap_up();
    if (failures == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up

  ////////////////////////////////////////
  // Bus master
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
    @(posedge aclk);
    awa <= a;
    wd  <= {16'h0000, d};
    awv <= 1'b1;
    wv  <= 1'b1;
    bre <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awready) awv <= 1'b0;
      if (wready) wv <= 1'b0;
      if (bvalid) break;
    end
    bre <= 1'b0;
    chk(bresp, er);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [33:0] e, input logic dc,
                    output logic [31:0] q);
    @(posedge aclk);
    rq.push_back('{v: e, dc: dc});
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arready) arv <= 1'b0;
      if (rvalid) break;
    end
    rre <= 1'b0;
    q = rdata;
  endtask : rd

  // Pin flip (0..4) or position read pulse (5..7) at cycle t
  task automatic tga(input logic [2:0] w, input int t);
    @(posedge aclk);
    while (cyc < t) @(posedge aclk);
    if (w < 3'd5) begin
      which <= w;
      req   <= 1'b1;
    end else rdp <= 3'b001 << (w - 3'd5);
    @(posedge aclk);
    req <= 1'b0;
    rdp <= 3'b000;
  endtask : tga

  task automatic cfg_core(input logic [1:0] bps, input logic [15:0] x, input logic [2:0] tin,
                          input logic down, input logic [2:0] mode);
    tcr_pkg::tcr_core_ctrl_t cc;
    cc     = '0;
    cc.bps = bps;
    wr(8'h18, cc, 2'b00);
    wr(8'h34, x, 2'b00);
    wr(8'h30, x, 2'b00);
    cc.reload_en = 1'b1;
    cc.oe        = 1'b1;
    cc.down      = down;
    cc.run       = 1'b1;
    cc.mode      = mode;
    cc.tin       = tin;
    skip         = 1'b1;
    have_tog     = 1'b0;
    wr(8'h18, cc, 2'b00);
  endtask : cfg_core

  ////////////////////////////////////////
  // Output watchers
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      failures++;
      wrap_up();
    end
  end

  always @(posedge aclk) begin
    if (rvalid && rre) begin
      rn = rq.pop_front();
      if (!rn.dc) chk({rresp, rdata}, rn.v);
    end
    if (cap_irq === 1'b1) capcnt++;
    if (core_irq === 1'b1) begin
      if (!skip && pq.size() > 0) begin
        pn = pq.pop_front();
        chk(cyc - last, pn.per);
        chk(uf, pn.uf);
      end
      skip    = 1'b0;
      last    = cyc;
      tog_due = cyc + 4;
    end
    if (cyc == tog_due) begin
      if (have_tog) chk(tog, !prev_tog);
      prev_tog = tog;
      have_tog = 1'b1;
    end
  end

  ////////////////////////////////////////
  // Main sequence
  initial begin
    tcr_pkg::tcr_aux_ctrl_t ac;
    logic [7:0]             offs [6];
    logic [31:0]            q, c1;
    logic [15:0]            x;
    logic [2:0]             tin;
    int unsigned            p;
    int                     n, e, t0;
    aresetn = 1'b0;
    {req, awv, wv, bre, arv, rre, skip, have_tog, prev_tog} = '0;
    {awa, ara, wd, which, rdp} = '0;
    {failures, check_count, cyc, last, capcnt} = '0;
    tog_due = -1;
    offs = '{8'h14, 8'h18, 8'h2C, 8'h30, 8'h34, 8'h38};
    void'($urandom(14959));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (offs[i]) rd(offs[i], 34'h0_0000_0000, 1'b0, q);
    rd(8'h3C, {2'b10, 32'h0000_0000}, 1'b0, q);
    wr(8'h3C, 16'h1234, 2'b10);
    // Reload on underflow, every prescale code
    for (int i = 0; i < 4; i++) begin
      x   = 16'(2 + $urandom_range(7));
      tin = 3'($urandom_range(1));
      p   = (int'(x) + 1) * (2 << i) * (1 << tin);
      cfg_core(i == 0 ? 2'b01 : i == 1 ? 2'b00 : i == 2 ? 2'b11 : 2'b10, x, tin, 1'b1, 3'b000);
      repeat (3) pq.push_back('{per: p, uf: 1'b1});
      while (pq.size() > 0) @(posedge aclk);
    end
    // Up count overflow reload
    cfg_core(2'b01, 16'hFFF0, 3'd0, 1'b0, 3'b000);
    repeat (3) pq.push_back('{per: 32, uf: 1'b0});
    while (pq.size() > 0) @(posedge aclk);
    // Counter mode on rising pin edges
    cfg_core(2'b00, 16'hFFFD, 3'd1, 1'b0, 3'b001);
    repeat (2) pq.push_back('{per: 120, uf: 1'b0});
    t0 = cyc + 8;
    for (int k = 0; k < 24; k++) tga(3'd4, t0 + 20 * k);
    while (pq.size() > 0) @(posedge aclk);
    // Gated timer, gate active low, pin idle low
    cfg_core(2'b01, 16'h0004, 3'd0, 1'b1, 3'b010);
    repeat (2) pq.push_back('{per: 10, uf: 1'b1});
    while (pq.size() > 0) @(posedge aclk);
    chk(capcnt, 0);
    // Down counting capture interval
    wr(8'h18, 16'h8000, 2'b00);
    ac            = '0;
    ac.capture_en = 1'b1;
    ac.clr        = 1'b1;
    ac.edge_sel   = 2'b01;
    ac.down       = 1'b1;
    ac.run        = 1'b1;
    wr(8'h14, ac, 2'b00);
    t0 = cyc + 8;
    tga(3'd0, t0);
    tga(3'd0, t0 + 40);
    tga(3'd0, t0 + 80);
    while (cyc < t0 + 100) @(posedge aclk);
    rd(8'h34, 34'h0_0000_0000, 1'b1, c1);
    tga(3'd0, t0 + 120);
    tga(3'd0, t0 + 200);
    while (cyc < t0 + 220) @(posedge aclk);
    rd(8'h34, 34'h0_0000_0000, 1'b1, q);
    chk(16'(c1 - q), 16'h000A);
    // Trigger source and edge selection
    for (int m = 0; m < 16; m++) begin
      ac          = '0;
      ac.enc_sel  = m[3];
      ac.edge_sel = 2'(m >> 1);
      ac.run      = 1'b1;
      wr(8'h14, ac, 2'b00);
      wr(8'h38, {15'h0000, m[0]}, 2'b00);
      e  = (m[2:1] == 2'b00) ? 0 : m[3] ? (m[2:1] == 2'b11 ? 4 : 2) : (m[2:1] == 2'b11 ? 2 : 1);
      if (!m[3] && m[2:1] == 2'b01) e += m[0] ? 3 : 1;
      n  = capcnt;
      t0 = cyc + 8;
      for (int k = 0; k < 9; k++) tga(k < 6 ? 3'(k / 2) : 3'(k - 1), t0 + 20 * k);
      repeat (30) @(posedge aclk);
      chk(capcnt - n, e);
    end
    wrap_up();
  end
endmodule : tb

// file: tb/tcr_pin_src.sv
`timescale 1ns/1ps
module tcr_pin_src #(
  parameter int MIN_HOLD = 16
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       req,
  input  wire logic [2:0] which,
  output logic [4:0]      pins
);
  int held [5];

  ////////////////////////////////////////
  // Pin levels, flipped on request once held long enough
  always_ff @(posedge aclk) begin
    for (int i = 0; i < 5; i++) begin
      if (!aresetn) begin
        pins[i] <= 1'b0;
        held[i] <= 0;
      end else if (req && int'(which) == i && held[i] >= MIN_HOLD) begin
        pins[i] <= ~pins[i];
        held[i] <= 0;
      end else if (held[i] < MIN_HOLD) begin
        held[i] <= held[i] + 1;
      end
    end
  end
endmodule : tcr_pin_src
